/* File: hdl/sensor_i2c_pkg.sv */
// Purpose: shared constants and types of the sensor command target
// Assumes: one 200 MHz core clock
// Notes: cycle counts derive from the printed times
package sensor_i2c_pkg;

	localparam logic [6:0]  TARGET_ADDR = 7'h70;
	localparam logic [15:0] CMD_SLEEP   = 16'hb098;
	localparam logic [15:0] CMD_WAKE    = 16'h3517;
	localparam logic [15:0] CMD_RESET   = 16'h805d;
	localparam logic [15:0] CMD_FULL_STR_T = 16'h7ca2;
	localparam logic [15:0] CMD_FULL_STR_H = 16'h5c24;
	localparam logic [15:0] CMD_FULL_NOS_T = 16'h7866;
	localparam logic [15:0] CMD_FULL_NOS_H = 16'h58e0;
	localparam logic [15:0] CMD_LOW_STR_T  = 16'h6458;
	localparam logic [15:0] CMD_LOW_STR_H  = 16'h44de;
	localparam logic [15:0] CMD_LOW_NOS_T  = 16'h609c;
	localparam logic [15:0] CMD_LOW_NOS_H  = 16'h401a;

	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] LAST_TX_BYTE  = 3'h5;
	localparam logic [2:0] CMD_BYTES     = 3'h2;
	localparam logic [2:0] WR_BYTE_MAX   = 3'h3;

	localparam real CLK_PERIOD_NS  = 5.0;
	localparam real POWER_UP_US    = 240.0;
	localparam real SOFT_RESET_US  = 240.0;
	localparam real CONV_FULL_MS   = 12.1;
	localparam real CONV_LOW_MS    = 0.8;
	localparam int  POWER_UP_CYCLES_DEF  = $rtoi(POWER_UP_US * 1.0e3 / CLK_PERIOD_NS);
	localparam int  SOFT_RESET_CYCLES_DEF = $rtoi(SOFT_RESET_US * 1.0e3 / CLK_PERIOD_NS);
	localparam int  CONV_FULL_CYCLES_DEF = $rtoi(CONV_FULL_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int  CONV_LOW_CYCLES_DEF  = $rtoi(CONV_LOW_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int  TIMER_W = 22;

	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] hum;
	} meas_result_type;

	typedef enum logic [2:0] {
		DEV_POWERUP,
		DEV_IDLE,
		DEV_SLEEP,
		DEV_MEASURE,
		DEV_RESETTING
	} dev_state_type;

	typedef enum logic [3:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR_ACK,
		BUS_WR,
		BUS_WR_ACK,
		BUS_RD,
		BUS_RD_ACK,
		BUS_STRETCH,
		BUS_IGNORE
	} bus_state_type;

endpackage

/* File: hdl/crc8_word.sv */
// Purpose: crc-8 over one 16-bit word, high byte first
// Assumes: purely combinational
// Notes: no reflection, no final xor
`timescale 1ns/1ps
module crc8_word
	import sensor_i2c_pkg::*;
(
	input  wire logic [15:0] word,
	output logic      [7:0]  crc
);

	always_comb
	begin
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--)
		begin
			if (c[7] ^ word[i])
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		crc = c;
	end

endmodule

/* File: hdl/sensor_i2c_command_target.sv */
// Purpose: two-wire target front end of a humidity and temperature sensor
// Assumes: scl and sda arrive asynchronously; sensor core results on core_clk
// Notes: pins are open drain, oe high means the pin is pulled low
`timescale 1ns/1ps
module sensor_i2c_command_target #(
	parameter int POWER_UP_CYCLES   = sensor_i2c_pkg::POWER_UP_CYCLES_DEF,
	parameter int SOFT_RESET_CYCLES = sensor_i2c_pkg::SOFT_RESET_CYCLES_DEF,
	parameter int CONV_FULL_CYCLES  = sensor_i2c_pkg::CONV_FULL_CYCLES_DEF,
	parameter int CONV_LOW_CYCLES   = sensor_i2c_pkg::CONV_LOW_CYCLES_DEF
)(
	input  wire logic                            core_clk,
	input  wire logic                            rst,
	input  wire logic                            scl_i,
	output logic                                 scl_o,
	output logic                                 scl_oe,
	input  wire logic                            sda_i,
	output logic                                 sda_o,
	output logic                                 sda_oe,
	input  wire sensor_i2c_pkg::meas_result_type sense_result,
	output logic                                 meas_start,
	output logic                                 meas_low_energy,
	output logic                                 calib_reload,
	output logic                                 asleep,
	output logic                                 busy
);
	import sensor_i2c_pkg::*;

	logic [1:0]           scl_sync_q;
	logic [1:0]           sda_sync_q;
	logic                 scl_q;
	logic                 sda_q;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 start_det;
	logic                 stop_det;
	dev_state_type        dev_state_q;
	logic [TIMER_W-1:0]   timer_q;
	logic                 stretch_q;
	logic                 temp_first_q;
	logic                 results_valid_q;
	meas_result_type      result_q;
	logic                 conv_done;
	bus_state_type        bus_state_q;
	logic [3:0]           bit_cnt_q;
	logic [7:0]           shift_q;
	logic                 rw_q;
	logic [2:0]           byte_idx_q;
	logic [15:0]          cmd_q;
	logic                 cmd_exec_q;
	logic                 cmd_is_meas;
	logic                 cmd_stretch;
	logic                 cmd_low;
	logic                 cmd_tfirst;
	logic                 hdr_ack;
	logic [15:0]          word0;
	logic [15:0]          word1;
	logic [7:0]           crc0;
	logic [7:0]           crc1;
	logic [7:0]           tx_byte;

	// pins pass two flops; the third stage only serves edge finding
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_q      <= scl_sync_q[1];
			sda_q      <= sda_sync_q[1];
		end
	end

	assign scl_rise  = scl_sync_q[1] & ~scl_q;
	assign scl_fall  = ~scl_sync_q[1] & scl_q;
	assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
	assign stop_det  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

	// command decode; anything else leaves cmd_is_meas low
	always_comb
	begin
		cmd_is_meas = 1'b1;
		cmd_stretch = 1'b0;
		cmd_low     = 1'b0;
		cmd_tfirst  = 1'b0;
		case (cmd_q)
			CMD_FULL_STR_T: {cmd_stretch, cmd_tfirst} = 2'h3;
			CMD_FULL_STR_H: cmd_stretch = 1'b1;
			CMD_FULL_NOS_T: cmd_tfirst = 1'b1;
			CMD_FULL_NOS_H: cmd_is_meas = 1'b1;
			CMD_LOW_STR_T:  {cmd_low, cmd_stretch, cmd_tfirst} = 3'h7;
			CMD_LOW_STR_H:  {cmd_low, cmd_stretch} = 2'h3;
			CMD_LOW_NOS_T:  {cmd_low, cmd_tfirst} = 2'h3;
			CMD_LOW_NOS_H:  cmd_low = 1'b1;
			default:        cmd_is_meas = 1'b0;
		endcase
	end

	assign conv_done = (dev_state_q == DEV_MEASURE) && (timer_q == '0);

	// device sequencing: power-up, idle, sleep, measure, soft reset
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			dev_state_q     <= DEV_POWERUP;
			timer_q         <= TIMER_W'(POWER_UP_CYCLES - 1);
			stretch_q       <= 1'b0;
			temp_first_q    <= 1'b0;
			meas_low_energy <= 1'b0;
			results_valid_q <= 1'b0;
			result_q        <= '0;
			meas_start      <= 1'b0;
			calib_reload    <= 1'b0;
		end
		else
		begin
			meas_start   <= 1'b0;
			calib_reload <= 1'b0;
			case (dev_state_q)
				DEV_POWERUP, DEV_RESETTING:
				begin
					if (timer_q == '0)
						dev_state_q <= DEV_IDLE;
					else
						timer_q <= timer_q - 1'b1;
				end
				DEV_MEASURE:
				begin
					if (conv_done)
					begin
						// both words caught together, order only matters on readout
						result_q        <= sense_result;
						results_valid_q <= 1'b1;
						dev_state_q     <= DEV_IDLE;
					end
					else
						timer_q <= timer_q - 1'b1;
				end
				DEV_SLEEP:
				begin
					if (cmd_exec_q && cmd_q == CMD_WAKE)
						dev_state_q <= DEV_IDLE;
				end
				default:
				begin
					if (cmd_exec_q)
					begin
						if (cmd_q == CMD_SLEEP)
							dev_state_q <= DEV_SLEEP;
						else if (cmd_q == CMD_RESET)
						begin
							dev_state_q     <= DEV_RESETTING;
							timer_q         <= TIMER_W'(SOFT_RESET_CYCLES - 1);
							calib_reload    <= 1'b1;
							results_valid_q <= 1'b0;
							stretch_q       <= 1'b0;
						end
						else if (cmd_is_meas)
						begin
							dev_state_q     <= DEV_MEASURE;
							meas_start      <= 1'b1;
							meas_low_energy <= cmd_low;
							stretch_q       <= cmd_stretch;
							temp_first_q    <= cmd_tfirst;
							results_valid_q <= 1'b0;
							if (cmd_low)
								timer_q <= TIMER_W'(CONV_LOW_CYCLES - 1);
							else
								timer_q <= TIMER_W'(CONV_FULL_CYCLES - 1);
						end
						// other codes fall through untouched
					end
				end
			endcase
		end
	end

	// header acceptance by device state
	always_comb
	begin
		hdr_ack = 1'b0;
		if (shift_q[7:1] == TARGET_ADDR)
		begin
			if (!shift_q[0])
				hdr_ack = (dev_state_q == DEV_IDLE) || (dev_state_q == DEV_SLEEP);
			else
				hdr_ack = ((dev_state_q == DEV_IDLE) && results_valid_q)
					|| ((dev_state_q == DEV_MEASURE) && stretch_q);
		end
	end

	assign word0 = temp_first_q ? result_q.temp : result_q.hum;
	assign word1 = temp_first_q ? result_q.hum : result_q.temp;

	crc8_word u_crc0 (
		.word (word0),
		.crc  (crc0)
	);

	crc8_word u_crc1 (
		.word (word1),
		.crc  (crc1)
	);

	// readout order: word, crc, word, crc, high byte first
	always_comb
	begin
		case (byte_idx_q)
			3'h0:    tx_byte = word0[15:8];
			3'h1:    tx_byte = word0[7:0];
			3'h2:    tx_byte = crc0;
			3'h3:    tx_byte = word1[15:8];
			3'h4:    tx_byte = word1[7:0];
			default: tx_byte = crc1;
		endcase
	end

	// bus engine; sda changes only after scl has fallen
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			bus_state_q <= BUS_IDLE;
			bit_cnt_q   <= '0;
			shift_q     <= '0;
			rw_q        <= 1'b0;
			byte_idx_q  <= '0;
			cmd_q       <= '0;
			cmd_exec_q  <= 1'b0;
			sda_oe      <= 1'b0;
			scl_oe      <= 1'b0;
		end
		else
		begin
			cmd_exec_q <= 1'b0;
			if (start_det)
			begin
				bus_state_q <= BUS_ADDR;
				bit_cnt_q   <= '0;
				sda_oe      <= 1'b0;
				scl_oe      <= 1'b0;
			end
			else if (stop_det)
			begin
				bus_state_q <= BUS_IDLE;
				sda_oe      <= 1'b0;
				scl_oe      <= 1'b0;
			end
			else
			begin
				case (bus_state_q)
					BUS_ADDR, BUS_WR:
					begin
						if (scl_rise)
						begin
							shift_q   <= {shift_q[6:0], sda_sync_q[1]};
							bit_cnt_q <= bit_cnt_q + 1'b1;
						end
						else if (scl_fall && bit_cnt_q == BITS_PER_BYTE)
						begin
							bit_cnt_q <= '0;
							if (bus_state_q == BUS_ADDR)
							begin
								byte_idx_q <= '0;
								rw_q       <= shift_q[0];
								if (hdr_ack)
								begin
									sda_oe      <= 1'b1;
									bus_state_q <= BUS_ADDR_ACK;
								end
								else
									bus_state_q <= BUS_IGNORE;
							end
							else
							begin
								// data bytes are always acked; extras are dropped
								sda_oe      <= 1'b1;
								bus_state_q <= BUS_WR_ACK;
								if (byte_idx_q == '0)
									cmd_q[15:8] <= shift_q;
								else if (byte_idx_q == 3'h1)
									cmd_q[7:0] <= shift_q;
								if (byte_idx_q != WR_BYTE_MAX)
									byte_idx_q <= byte_idx_q + 1'b1;
							end
						end
					end
					BUS_ADDR_ACK:
					begin
						if (scl_fall)
						begin
							if (!rw_q)
							begin
								sda_oe      <= 1'b0;
								bus_state_q <= BUS_WR;
							end
							else if (results_valid_q)
							begin
								shift_q     <= tx_byte;
								sda_oe      <= ~tx_byte[7];
								bus_state_q <= BUS_RD;
							end
							else
							begin
								sda_oe      <= 1'b0;
								scl_oe      <= 1'b1;
								bus_state_q <= BUS_STRETCH;
							end
						end
					end
					BUS_STRETCH:
					begin
						// sda is set a cycle before scl is let go
						if (results_valid_q)
						begin
							shift_q     <= tx_byte;
							sda_oe      <= ~tx_byte[7];
							bus_state_q <= BUS_RD;
						end
					end
					BUS_WR_ACK:
					begin
						if (scl_fall)
						begin
							sda_oe      <= 1'b0;
							bus_state_q <= BUS_WR;
							cmd_exec_q  <= (byte_idx_q == CMD_BYTES);
						end
					end
					BUS_RD:
					begin
						scl_oe <= 1'b0;
						if (scl_fall)
						begin
							if (bit_cnt_q == BITS_PER_BYTE - 1'b1)
							begin
								bit_cnt_q   <= '0;
								sda_oe      <= 1'b0;
								bus_state_q <= BUS_RD_ACK;
							end
							else
							begin
								bit_cnt_q <= bit_cnt_q + 1'b1;
								shift_q   <= {shift_q[6:0], 1'b0};
								sda_oe    <= ~shift_q[6];
							end
						end
					end
					BUS_RD_ACK:
					begin
						if (scl_rise)
						begin
							// a nack or the last crc ends the readout
							if (sda_sync_q[1] || byte_idx_q == LAST_TX_BYTE)
								bus_state_q <= BUS_IGNORE;
							else
							begin
								byte_idx_q <= byte_idx_q + 1'b1;
								bit_cnt_q  <= 4'h1;
							end
						end
						else if (scl_fall && bit_cnt_q != '0)
						begin
							bit_cnt_q   <= '0;
							shift_q     <= tx_byte;
							sda_oe      <= ~tx_byte[7];
							bus_state_q <= BUS_RD;
						end
					end
					default:
					begin
						sda_oe <= 1'b0;
						scl_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign asleep  = (dev_state_q == DEV_SLEEP);
	assign busy    = (dev_state_q != DEV_IDLE) && (dev_state_q != DEV_SLEEP);

endmodule

/* File: dv/sensor_i2c_monitor.sv */
// Purpose: timing and sequencing checks of the sensor command target
// Assumes: one core_clk domain, bound by the lines below the module
// Notes: windows of a few cycles absorb the pin synchronisers
`timescale 1ns/1ps
module sensor_i2c_monitor #(
	parameter int POWER_UP_CYCLES   = 20,
	parameter int SOFT_RESET_CYCLES = 40,
	parameter int CONV_FULL_CYCLES  = 400,
	parameter int CONV_LOW_CYCLES   = 100
)(
	input wire logic                            core_clk,
	input wire logic                            rst,
	input wire logic                            scl_i,
	input wire logic                            scl_o,
	input wire logic                            scl_oe,
	input wire logic                            sda_i,
	input wire logic                            sda_o,
	input wire logic                            sda_oe,
	input wire sensor_i2c_pkg::meas_result_type sense_result,
	input wire logic                            meas_start,
	input wire logic                            meas_low_energy,
	input wire logic                            calib_reload,
	input wire logic                            asleep,
	input wire logic                            busy
);
	import sensor_i2c_pkg::*;
	localparam int PU_LO = POWER_UP_CYCLES - 3;
	localparam int PU_HI = POWER_UP_CYCLES + 3;
	localparam int SR_LO = SOFT_RESET_CYCLES - 3;
	localparam int SR_HI = SOFT_RESET_CYCLES + 3;
	localparam int CF_LO = CONV_FULL_CYCLES - 4;
	localparam int CF_HI = CONV_FULL_CYCLES + 4;
	localparam int CL_LO = CONV_LOW_CYCLES - 4;
	localparam int CL_HI = CONV_LOW_CYCLES + 4;
	default clocking dflt_clk @(posedge core_clk);
	endclocking
	default disable iff (rst);

	reset_state_a: assert property ($fell(rst) |-> !scl_oe && !sda_oe && busy && !asleep)
		else $error("outputs not quiet after reset");
	power_up_a: assert property ($fell(rst) |-> ##[PU_LO:PU_HI] $fell(busy))
		else $error("power-up delay wrong");
	start_pulse_a: assert property (meas_start |=> !meas_start && busy)
		else $error("measurement start not a single pulse");
	reload_pulse_a: assert property (calib_reload |=> !calib_reload && busy)
		else $error("reload not a single pulse");
	reset_time_a: assert property (calib_reload |-> ##[SR_LO:SR_HI] $fell(busy))
		else $error("soft reset time wrong");
	full_conv_a: assert property (meas_start ##1 !meas_low_energy |-> ##[CF_LO:CF_HI] $fell(busy))
		else $error("full conversion time wrong");
	low_conv_a: assert property (meas_start ##1 meas_low_energy |-> ##[CL_LO:CL_HI] $fell(busy))
		else $error("low energy conversion time wrong");
	sleep_quiet_a: assert property (asleep |-> !meas_start && !calib_reload && !busy)
		else $error("activity while asleep");
	stretch_cause_a: assert property ($rose(scl_oe) |-> busy)
		else $error("stretch without conversion");
	stretch_end_a: assert property (scl_oe && !busy |-> ##[1:3] !scl_oe)
		else $error("stretch outlasts conversion");
	open_drain_a: assert property (!scl_o && !sda_o)
		else $error("pin data value not low");
	sda_timing_a: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("sda changed while scl high");
endmodule

bind sensor_i2c_command_target sensor_i2c_monitor #(
	.POWER_UP_CYCLES(POWER_UP_CYCLES), .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES),
	.CONV_FULL_CYCLES(CONV_FULL_CYCLES), .CONV_LOW_CYCLES(CONV_LOW_CYCLES)
) sensor_i2c_monitor_inst (
	.core_clk(core_clk), .rst(rst), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .sense_result(sense_result),
	.meas_start(meas_start), .meas_low_energy(meas_low_energy),
	.calib_reload(calib_reload), .asleep(asleep), .busy(busy)
);

/* File: dv/i2c_master.sv */
// Purpose: behavioural two-wire bus master
// Assumes: open-drain wires with pull-ups outside
// Notes: 64 ns scl period, waits out clock stretching
`timescale 1ns/1ps
module i2c_master (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_pull,
	output logic      sda_pull
);
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// half periods of 32 ns give scl a 64 ns period, about 15.6 mhz
	task automatic bit_xfer(input logic b, output logic r);
		int n;
		sda_pull = !b; // only pulls low, pull-ups give high
		#16 scl_pull = 1'b0;
		for (n = 0; n < 4000 && !scl; n++)
			#5;
		#16 r = sda;
		#16 scl_pull = 1'b1;
		#16;
	endtask
	task automatic start_cond();
		sda_pull = 1'b0;
		#16 scl_pull = 1'b0;
		#16 sda_pull = 1'b1; // every transfer opens with start
		#16 scl_pull = 1'b1;
		#16;
	endtask
	task automatic stop_cond();
		sda_pull = 1'b1;
		#16 scl_pull = 1'b0;
		#16 sda_pull = 1'b0;
		#16;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic ackm, output logic [7:0] q,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], q[i]); // msb first
		bit_xfer(ackm, a); // ack asks for more, nack ends a read
		ack = !a;
	endtask
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the sensor command target
// Assumes: master model on the far side, wires pulled up
// Notes: short delay counts keep the run small
`timescale 1ns/1ps
module tb_top;
	import sensor_i2c_pkg::*;
	localparam int CF = 400;
	localparam int CL = 100;
	localparam logic [15:0] CODES [0:7] = '{CMD_FULL_STR_T, CMD_FULL_STR_H, CMD_FULL_NOS_T,
		CMD_FULL_NOS_H, CMD_LOW_STR_T, CMD_LOW_STR_H, CMD_LOW_NOS_T, CMD_LOW_NOS_H};
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	meas_result_type sense_result = '0;
	logic            scl_oe, sda_oe, m_scl, m_sda, meas_start, meas_low_energy;
	logic            calib_reload, asleep, busy;
	logic [7:0]      rb [0:5];
	int              error_cnt = 0, n_compared = 0, cyc = 0, meas_cnt = 0, calib_cnt = 0;
	wire             scl = !(scl_oe | m_scl);
	wire             sda = !(sda_oe | m_sda);

	sensor_i2c_command_target #(.POWER_UP_CYCLES(20), .SOFT_RESET_CYCLES(40),
		.CONV_FULL_CYCLES(CF), .CONV_LOW_CYCLES(CL)) sensor_i2c_command_target_inst (
		.core_clk(core_clk), .rst(rst), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe(sda_oe), .sense_result(sense_result),
		.meas_start(meas_start), .meas_low_energy(meas_low_energy),
		.calib_reload(calib_reload), .asleep(asleep), .busy(busy));
	i2c_master i2c_master_inst (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));

	always #2.5 core_clk = !core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		meas_cnt <= meas_cnt + meas_start;
		calib_cnt <= calib_cnt + calib_reload;
		if (cyc == 60000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check_bit(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bench copy of the checksum, written apart from the design
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hff;
		for (int k = 15; k >= 0; k--)
			c = (c[7] ^ w[k]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic cmd(input logic [15:0] c);
		logic [7:0] q;
		logic       a0, a1, a2;
		i2c_master_inst.start_cond();
		i2c_master_inst.xbyte({TARGET_ADDR, 1'b0}, 1'b1, q, a0);
		i2c_master_inst.xbyte(c[15:8], 1'b1, q, a1);
		i2c_master_inst.xbyte(c[7:0], 1'b1, q, a2);
		i2c_master_inst.stop_cond();
		check_bit("cmd_ack", 1'b1, a0 & a1 & a2);
	endtask
	task automatic rd(input int n, output logic ack);
		logic a;
		i2c_master_inst.start_cond();
		i2c_master_inst.xbyte({TARGET_ADDR, 1'b1}, 1'b1, rb[0], ack);
		for (int k = 0; k < n; k++)
			i2c_master_inst.xbyte(8'hff, k == n - 1, rb[k], a);
		i2c_master_inst.stop_cond();
	endtask

	task automatic t_power_up();
		logic a;
		check_bit("busy_pu", 1'b1, busy);
		check_bit("asleep_pu", 1'b0, asleep);
		repeat (30) @(posedge core_clk);
		check_bit("idle_pu", 1'b0, busy);
		rd(0, a);
		check_bit("rd_nothing", 1'b0, a);
	endtask
	task automatic t_address();
		logic [7:0] q;
		logic       a;
		logic [7:0] bad [0:2] = '{8'he2, 8'h60, 8'hf1};
		for (int i = 0; i < 3; i++)
		begin
			i2c_master_inst.start_cond();
			i2c_master_inst.xbyte(bad[i], 1'b1, q, a);
			i2c_master_inst.stop_cond();
			check_bit("bad_addr", 1'b0, a);
		end
	endtask
	task automatic t_unknown_sleep();
		int m0;
		m0 = meas_cnt;
		cmd(16'h1234);
		check_bit("unk_busy", 1'b0, busy);
		cmd(CMD_SLEEP);
		check_bit("asleep", 1'b1, asleep);
		cmd(CMD_FULL_STR_T);
		check_bit("still_asleep", 1'b1, asleep);
		check_val("no_meas", 16'(m0), 16'(meas_cnt));
		cmd(CMD_WAKE);
		check_bit("awake", 1'b0, asleep);
	endtask
	task automatic t_measure(input int i);
		logic [15:0] t, h, w0, w1;
		logic        low, str, a;
		int          m0;
		low = i >= 4;
		str = i % 4 < 2;
		t = 16'h6a00 + 16'(i);
		h = 16'h9b10 - 16'(i);
		w0 = (i % 2 == 0) ? t : h;
		w1 = (i % 2 == 0) ? h : t;
		@(posedge core_clk);
		sense_result <= {t, h};
		m0 = meas_cnt;
		cmd(CODES[i]);
		check_val("meas_pulse", 16'(m0 + 1), 16'(meas_cnt));
		check_bit("low_energy", low, meas_low_energy);
		if (!str && !low)
			rd(0, a);
		if (!str && !low)
			check_bit("hdr_busy", 1'b0, a);
		if (!str)
			repeat (low ? CL : CF) @(posedge core_clk); // bus kept quiet
		rd(6, a);
		check_bit("hdr_done", 1'b1, a);
		check_val("word0", w0, {rb[0], rb[1]});
		check_val("crc0", 16'(crc8(w0)), 16'(rb[2]));
		check_val("word1", w1, {rb[3], rb[4]});
		check_val("crc1", 16'(crc8(w1)), 16'(rb[5]));
	endtask
	task automatic t_abort();
		logic [7:0] q;
		logic       a;
		i2c_master_inst.start_cond();
		i2c_master_inst.xbyte({TARGET_ADDR, 1'b1}, 1'b1, q, a);
		i2c_master_inst.xbyte(8'hff, 1'b0, q, a);
		i2c_master_inst.xbyte(8'hff, 1'b1, q, a);
		i2c_master_inst.xbyte(8'hff, 1'b1, q, a);
		i2c_master_inst.stop_cond();
		check_val("after_nack", 16'h00ff, 16'(q));
	endtask
	task automatic t_soft();
		int   c0;
		logic a;
		c0 = calib_cnt;
		cmd(CMD_RESET); // sent only while idle
		check_val("reload", 16'(c0 + 1), 16'(calib_cnt));
		check_bit("busy_sr", 1'b1, busy);
		repeat (50) @(posedge core_clk);
		check_bit("idle_sr", 1'b0, busy);
		rd(0, a);
		check_bit("rd_discard", 1'b0, a);
	endtask

	initial
	begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		t_power_up();
		t_address();
		t_unknown_sleep();
		for (int i = 0; i < 8; i++)
			t_measure(i);
		t_abort();
		t_soft();
		complete_run();
	end
endmodule
